//--- include/coproc_trap_pkg.sv
package coproc_trap_pkg;

   // Syndrome field positions
   localparam int SYN_W = 25;
   localparam int CV_BIT = 24;
   localparam int CODE_FIELD_A_HI = 23;
   localparam int CODE_FIELD_A_LO = 20;
   localparam int FIRST_OPCODE_FIELD_HI = 19;
   localparam int FIRST_OPCODE_FIELD_LO = 16;
   localparam int IMM_HI = 19;
   localparam int IMM_LO = 12;
   localparam int RSV_HI = 11;
   localparam int RSV_LO = 10;
   localparam int XREG2_HI = 14;
   localparam int XREG2_LO = 10;
   localparam int XREG1_HI = 9;
   localparam int XREG1_LO = 5;
   localparam int MINOR_HI = 4;
   localparam int MINOR_LO = 1;
   localparam int OFS_BIT = 4;
   localparam int AM_HI = 3;
   localparam int AM_LO = 1;
   localparam int DIR_BIT = 0;

   // Syndrome values
   localparam logic [3:0] CODE_FIELD_A_ALWAYS = 4'hE;
   localparam logic [3:0] SPEC_PC = 4'hF;
   localparam logic [4:0] SPEC_WIDE_ZERO = 5'h1F;
   localparam logic [3:0] SPACE_SYSTEM = 4'hF;
   localparam logic [3:0] SPACE_DEBUG = 4'hE;
   localparam logic [5:0] EC_TWO_REG_SYS = 6'h04;
   localparam logic [5:0] EC_LOAD_STORE = 6'h06;
   localparam logic [5:0] EC_TWO_REG_DBG = 6'h0C;

   // Kind of trapped instruction
   typedef enum logic [0:0] {
      KIND_TWO_REG = 1'b0,
      KIND_LOAD_STORE = 1'b1
   } trap_kind_t;

   // Register map, byte addresses
   localparam logic [3:0] ADDR_SYN_TWO_REG = 4'h0;
   localparam logic [3:0] ADDR_SYN_LOAD_STORE = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_CONTROL = 4'hC;

   // Control register bits
   localparam int CTL_MIXED_CV = 0;
   localparam int CTL_PASSED_ALWAYS = 1;
   localparam int CTL_UNPRED_WIDE_ZERO = 2;
   localparam int CTL_W = 3;
   localparam logic [CTL_W-1:0] CTL_RESET = 3'h0;

   // Status register bits
   localparam int STS_EC_HI = 5;
   localparam int STS_EC_LO = 0;
   localparam int STS_UNDEF = 8;
   localparam int STS_TRAP = 9;

endpackage : coproc_trap_pkg

//--- hw/coproc_trap_syndrome_encoder.sv
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module coproc_trap_syndrome_encoder
(
   input wire logic clk_sys,
   input wire logic rst,
   // Classic Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Trapped instruction from the pipeline
   input wire logic trap_valid,
   input wire logic trap_kind,
   input wire logic from_wide_state,
   input wire logic mixed_width,
   input wire logic is_conditional,
   input wire logic code_field_a_passed_known,
   input wire logic [3:0] code_field_a,
   input wire logic is_unpredictable,
   input wire logic [3:0] coproc_space,
   input wire logic is_read,
   input wire logic [3:0] first_opcode_field,
   input wire logic [3:0] minor_coproc_reg_field,
   input wire logic [3:0] first_xfer_reg_field,
   input wire logic [3:0] second_xfer_reg_field,
   input wire logic [3:0] base_reg_field,
   input wire logic [7:0] byte_immediate_field,
   input wire logic literal_form,
   input wire logic pre_index,
   input wire logic writeback,
   input wire logic add_offset,
   input wire logic trace_target,
   input wire logic trace_undef,
   // Exception report
   output logic exc_valid,
   output logic [5:0] exception_class_code,
   output logic [24:0] syndrome_detail,
   output logic undef_take
);

   ////////////////////////////////////////////////////////////////////////////

   typedef struct packed {
      logic [coproc_trap_pkg::SYN_W-1:0] syn_two_reg;
      logic [coproc_trap_pkg::SYN_W-1:0] syn_load_store;
      logic [5:0] last_class;
      logic trap_seen;
      logic undef_seen;
      logic [coproc_trap_pkg::CTL_W-1:0] ctrl;
      logic ack;
      logic [31:0] rdata;
      logic exc_valid;
      logic [5:0] exc_class;
      logic [coproc_trap_pkg::SYN_W-1:0] exc_syn;
      logic undef;
   } state_t;

   state_t state_r;
   state_t state_nxt;

   ////////////////////////////////////////////////////////////////////////////

   // Wide view of a 32-bit-state register; low registers map one to one
   function automatic logic [4:0] wide_spec(input logic [3:0] spec, input logic unpred,
                                            input logic unpred_zero);
      logic [4:0] res;
      res = {1'b0, spec};
      if (spec == coproc_trap_pkg::SPEC_PC)
      begin
         if (!unpred || unpred_zero)
            res = coproc_trap_pkg::SPEC_WIDE_ZERO;
         else
            res = {1'b0, spec};
      end
      return res;
   endfunction : wide_spec

   // Byte-lane merge of a software write
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wdat,
                                              input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            res[i*8 +: 8] = wdat[i*8 +: 8];
      end
      return res;
   endfunction : lane_merge

   // Registers reachable from the bus; anything unmapped reads zero and ignores writes
   typedef enum logic [2:0]
   {
      SEL_NONE = 3'b000,
      SEL_SYN_TWO_REG = 3'b001,
      SEL_SYN_LOAD_STORE = 3'b010,
      SEL_STATUS = 3'b011,
      SEL_CONTROL = 3'b100
   } reg_sel_t;

   // Address decode, shared by the read path and the write path
   function automatic reg_sel_t reg_decode(input logic [3:0] adr);
      reg_sel_t res;
      case (adr)
         coproc_trap_pkg::ADDR_SYN_TWO_REG:
            res = SEL_SYN_TWO_REG;
         coproc_trap_pkg::ADDR_SYN_LOAD_STORE:
            res = SEL_SYN_LOAD_STORE;
         coproc_trap_pkg::ADDR_STATUS:
            res = SEL_STATUS;
         coproc_trap_pkg::ADDR_CONTROL:
            res = SEL_CONTROL;
         default:
            res = SEL_NONE;
      endcase
      return res;
   endfunction : reg_decode

   // Status word: last class and the two sticky flags
   function automatic logic [31:0] status_word(input logic trap, input logic undef,
                                               input logic [5:0] cls);
      logic [31:0] res;
      res = '0;
      res[coproc_trap_pkg::STS_EC_HI:coproc_trap_pkg::STS_EC_LO] = cls;
      res[coproc_trap_pkg::STS_UNDEF] = undef;
      res[coproc_trap_pkg::STS_TRAP] = trap;
      return res;
   endfunction : status_word

   // Read value of the selected register, zero-extended to the bus width
   function automatic logic [31:0] read_word(input state_t s, input reg_sel_t sel);
      logic [31:0] res;
      res = '0;
      case (sel)
         SEL_SYN_TWO_REG:
            res[coproc_trap_pkg::SYN_W-1:0] = s.syn_two_reg;
         SEL_SYN_LOAD_STORE:
            res[coproc_trap_pkg::SYN_W-1:0] = s.syn_load_store;
         SEL_STATUS:
            res = status_word(s.trap_seen, s.undef_seen, s.last_class);
         SEL_CONTROL:
            res[coproc_trap_pkg::CTL_W-1:0] = s.ctrl;
         default:
            res = '0;
      endcase
      return res;
   endfunction : read_word

   ////////////////////////////////////////////////////////////////////////////

   logic [coproc_trap_pkg::SYN_W-1:0] syn_new;
   logic cv_new;
   logic [3:0] code_field_a_new;
   logic [5:0] class_new;
   logic is_two_reg;
   logic space_ok;
   logic take_undef;
   logic take_trap;
   logic req;
   logic [31:0] merged;
   logic [31:0] cur;
   reg_sel_t bus_sel;

   // Condition-valid flag and condition field, common to both kinds
   always_comb
   begin
      cv_new = 1'b1;
      code_field_a_new = coproc_trap_pkg::CODE_FIELD_A_ALWAYS;
      if (!from_wide_state)
      begin
         if (mixed_width)
         begin
            // Software must look at the saved block state when the flag is clear
            cv_new = state_r.ctrl[coproc_trap_pkg::CTL_MIXED_CV];
            // An unconditional instruction carries no code of its own to report
            if (cv_new && is_conditional)
               code_field_a_new = code_field_a;
            else if (!cv_new)
               code_field_a_new = 4'h0;
         end
         else if (is_conditional)
         begin
            if (code_field_a_passed_known && state_r.ctrl[coproc_trap_pkg::CTL_PASSED_ALWAYS])
               code_field_a_new = coproc_trap_pkg::CODE_FIELD_A_ALWAYS;
            else
               code_field_a_new = code_field_a;
         end
      end
   end

   // Syndrome packing and class selection
   always_comb
   begin
      is_two_reg = (trap_kind == coproc_trap_pkg::KIND_TWO_REG);
      syn_new = '0;
      syn_new[coproc_trap_pkg::CV_BIT] = cv_new;
      syn_new[coproc_trap_pkg::CODE_FIELD_A_HI:coproc_trap_pkg::CODE_FIELD_A_LO] = code_field_a_new;
      space_ok = 1'b1;
      class_new = coproc_trap_pkg::EC_LOAD_STORE;
      if (is_two_reg)
      begin
         syn_new[coproc_trap_pkg::FIRST_OPCODE_FIELD_HI:coproc_trap_pkg::FIRST_OPCODE_FIELD_LO] = first_opcode_field;
         syn_new[coproc_trap_pkg::XREG2_HI:coproc_trap_pkg::XREG2_LO] =
            wide_spec(second_xfer_reg_field, is_unpredictable,
                      state_r.ctrl[coproc_trap_pkg::CTL_UNPRED_WIDE_ZERO]);
         syn_new[coproc_trap_pkg::XREG1_HI:coproc_trap_pkg::XREG1_LO] =
            wide_spec(first_xfer_reg_field, is_unpredictable,
                      state_r.ctrl[coproc_trap_pkg::CTL_UNPRED_WIDE_ZERO]);
         syn_new[coproc_trap_pkg::MINOR_HI:coproc_trap_pkg::MINOR_LO] =
            minor_coproc_reg_field;
         syn_new[coproc_trap_pkg::DIR_BIT] = is_read;
         if (coproc_space == coproc_trap_pkg::SPACE_SYSTEM)
            class_new = coproc_trap_pkg::EC_TWO_REG_SYS;
         else if (coproc_space == coproc_trap_pkg::SPACE_DEBUG)
            class_new = coproc_trap_pkg::EC_TWO_REG_DBG;
         else
            space_ok = 1'b0;
      end
      else
      begin
         syn_new[coproc_trap_pkg::IMM_HI:coproc_trap_pkg::IMM_LO] = byte_immediate_field;
         syn_new[coproc_trap_pkg::RSV_HI:coproc_trap_pkg::RSV_LO] = 2'h0;
         // Literal form has no base register; zero is reported there
         if (!literal_form)
            syn_new[coproc_trap_pkg::XREG1_HI:coproc_trap_pkg::XREG1_LO] =
               wide_spec(base_reg_field, is_unpredictable,
                         state_r.ctrl[coproc_trap_pkg::CTL_UNPRED_WIDE_ZERO]);
         syn_new[coproc_trap_pkg::OFS_BIT] = add_offset;
         syn_new[coproc_trap_pkg::AM_HI:coproc_trap_pkg::AM_LO] =
            {literal_form, pre_index, writeback};
         syn_new[coproc_trap_pkg::DIR_BIT] = is_read;
      end
      // Undefined trace access pre-empts the trap, so no syndrome is written
      take_undef = trap_valid && is_two_reg && trace_target && trace_undef;
      take_trap = trap_valid && space_ok && !take_undef;
   end

   ////////////////////////////////////////////////////////////////////////////

   // Register file and next state
   always_comb
   begin
      state_nxt = state_r;
      // Ack is registered; a strobe held through its ack is not taken twice
      req = wb_cyc_i && wb_stb_i && !state_r.ack;
      bus_sel = reg_decode(wb_adr_i);
      cur = read_word(state_r, bus_sel);
      merged = lane_merge(cur, wb_dat_i, wb_sel_i);
      state_nxt.ack = req;
      state_nxt.rdata = req ? cur : 32'h00000000;
      if (req && wb_we_i)
      begin
         case (bus_sel)
            SEL_SYN_TWO_REG:
               state_nxt.syn_two_reg = merged[coproc_trap_pkg::SYN_W-1:0];
            SEL_SYN_LOAD_STORE:
            begin
               state_nxt.syn_load_store = merged[coproc_trap_pkg::SYN_W-1:0];
               state_nxt.syn_load_store[coproc_trap_pkg::RSV_HI:coproc_trap_pkg::RSV_LO] =
                  2'h0;
            end
            SEL_STATUS:
            begin
               // Write one to clear the sticky flags, through the lane that holds them
               if (wb_sel_i[coproc_trap_pkg::STS_UNDEF / 8] &&
                   wb_dat_i[coproc_trap_pkg::STS_UNDEF])
                  state_nxt.undef_seen = 1'b0;
               if (wb_sel_i[coproc_trap_pkg::STS_TRAP / 8] &&
                   wb_dat_i[coproc_trap_pkg::STS_TRAP])
                  state_nxt.trap_seen = 1'b0;
            end
            SEL_CONTROL:
               state_nxt.ctrl = merged[coproc_trap_pkg::CTL_W-1:0];
            default:
               state_nxt.ctrl = state_r.ctrl;
         endcase
      end
      // A new exception overrides a software write in the same cycle
      state_nxt.exc_valid = take_trap;
      state_nxt.undef = take_undef;
      if (take_undef)
         state_nxt.undef_seen = 1'b1;
      if (take_trap)
      begin
         state_nxt.trap_seen = 1'b1;
         state_nxt.last_class = class_new;
         state_nxt.exc_class = class_new;
         state_nxt.exc_syn = syn_new;
         if (is_two_reg)
            state_nxt.syn_two_reg = syn_new;
         else
            state_nxt.syn_load_store = syn_new;
      end
   end

   ////////////////////////////////////////////////////////////////////////////

   // Syndrome contents are cleared only to keep simulation tidy
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_r <= '0;
         state_r.ctrl <= coproc_trap_pkg::CTL_RESET;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign wb_dat_o = state_r.rdata;
   assign wb_ack_o = state_r.ack;
   assign exc_valid = state_r.exc_valid;
   assign exception_class_code = state_r.exc_class;
   assign syndrome_detail = state_r.exc_syn;
   assign undef_take = state_r.undef;

endmodule : coproc_trap_syndrome_encoder

`default_nettype wire

//--- testbench/coproc_trap_properties.sv
`timescale 1ns/1ps
`default_nettype none
module coproc_trap_checker
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic trap_valid,
   input wire logic trap_kind,
   input wire logic from_wide_state,
   input wire logic [3:0] coproc_space,
   input wire logic is_read,
   input wire logic [3:0] first_opcode_field,
   input wire logic [3:0] minor_coproc_reg_field,
   input wire logic [3:0] second_xfer_reg_field,
   input wire logic [7:0] byte_immediate_field,
   input wire logic trace_target,
   input wire logic trace_undef,
   input wire logic exc_valid,
   input wire logic [5:0] exception_class_code,
   input wire logic [24:0] syndrome_detail,
   input wire logic undef_take
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire logic tu_hit = trace_target && trace_undef;
   wire logic two_r = trap_valid && !trap_kind && coproc_space[3:1] == 3'h7 && !tu_hit;
   wire logic ls_r = trap_valid && trap_kind;
   ////////////////////////////////////////////////////////////
   ls_class_a: assert property (ls_r |=> exc_valid && exception_class_code == 6'h06)
      else $error("load/store class wrong");
   sys_class_a: assert property (two_r && coproc_space == 4'hF |=> exc_valid
      && exception_class_code == 6'h04) else $error("system space class wrong");
   dbg_class_a: assert property (two_r && coproc_space == 4'hE |=> exc_valid
      && exception_class_code == 6'h0C) else $error("debug space class wrong");
   undef_wins_a: assert property (trap_valid && !trap_kind && coproc_space == 4'hE && tu_hit
      |=> undef_take && !exc_valid) else $error("undefined access not preferred");
   minor_copy_a: assert property (two_r |=>
      syndrome_detail[4:1] == $past(minor_coproc_reg_field)) else $error("minor field wrong");
   opc_copy_a: assert property (two_r |=>
      syndrome_detail[19:16] == $past(first_opcode_field)) else $error("opcode field wrong");
   xreg_map_a: assert property (two_r && second_xfer_reg_field != 4'hF |=>
      syndrome_detail[14:10] == {1'b0, $past(second_xfer_reg_field)}) else $error("reg wrong");
   dir_bit_a: assert property (two_r || ls_r |=>
      syndrome_detail[0] == $past(is_read)) else $error("direction bit wrong");
   imm_copy_a: assert property (ls_r |=> syndrome_detail[11:10] == 2'h0
      && syndrome_detail[19:12] == $past(byte_immediate_field)) else $error("immediate wrong");
   wide_state_a: assert property ((two_r || ls_r) && from_wide_state |=>
      syndrome_detail[24:20] == 5'h1E) else $error("wide state flag or code wrong");
endmodule : coproc_trap_checker
bind coproc_trap_syndrome_encoder coproc_trap_checker u_coproc_trap_checker
(
   .clk_sys(clk_sys), .rst(rst), .trap_valid(trap_valid), .trap_kind(trap_kind),
   .from_wide_state(from_wide_state), .coproc_space(coproc_space), .is_read(is_read),
   .first_opcode_field(first_opcode_field), .minor_coproc_reg_field(minor_coproc_reg_field),
   .second_xfer_reg_field(second_xfer_reg_field), .byte_immediate_field(byte_immediate_field),
   .trace_target(trace_target), .trace_undef(trace_undef), .exc_valid(exc_valid),
   .exception_class_code(exception_class_code), .syndrome_detail(syndrome_detail),
   .undef_take(undef_take)
);
`default_nettype wire

//--- testbench/pipe.sv
`timescale 1ns/1ps
`default_nettype none
module pipe
(
   input wire logic clk_sys
);
   logic v, k, ws, mw, cn, kp, un, rd, lt, pi, wb, ad, tt, tu;
   logic [3:0] cc, sp, o1, mi, r1, r2, bs;
   logic [7:0] im;
   // Spaces 12 and 13 are sent too, so that ignored traps get seen
   task automatic fill(input logic vv);
      logic [31:0] a;
      logic [31:0] b;
      a = $urandom;
      b = $urandom;
      v <= vv;
      {k, ws, cn, kp, un, rd, lt, pi, wb, ad, tu, im, sp} <= {a[20:2], 2'h3, a[1:0]};
      {cc, o1, mi, r1, r2, bs} <= b[23:0];
      // Mixed width never comes from wide state; trace registers sit in space 14 only
      mw <= !a[19] && a[30];
      tt <= a[1:0] == 2'h2 && a[31];
   endtask : fill
   task automatic issue();
      @(posedge clk_sys);
      fill($urandom % 4 != 0);
   endtask : issue
   initial fill(1'b0);
endmodule : pipe
`default_nettype wire

//--- testbench/test_coproc_trap_syndrome_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module test_coproc_trap_syndrome_encoder;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic wb_ack_o, exc_valid, undef_take, ev, eu, vf, blind, ts_m, us_m, hide = 1'b0;
   logic [5:0] exception_class_code, xc, lc_m;
   logic [24:0] syndrome_detail, es, r2_m, rl_m;
   logic [3:0] cd;
   logic [2:0] ctl_m = 3'h0;
   logic [2:0] ph [3] = '{3'h0, 3'h5, 3'h2};
   int n_errors = 0, cmp_count = 0, cyc = 0;
   always #50 clk_sys = ~clk_sys;
   pipe u_pipe (.clk_sys(clk_sys));
   coproc_trap_syndrome_encoder u_coproc_trap_syndrome_encoder
   (
      .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .exc_valid(exc_valid), .exception_class_code(exception_class_code),
      .syndrome_detail(syndrome_detail), .undef_take(undef_take),
      .trap_valid(u_pipe.v), .trap_kind(u_pipe.k), .from_wide_state(u_pipe.ws),
      .mixed_width(u_pipe.mw), .is_conditional(u_pipe.cn), .code_field_a_passed_known(u_pipe.kp),
      .code_field_a(u_pipe.cc), .is_unpredictable(u_pipe.un), .coproc_space(u_pipe.sp),
      .is_read(u_pipe.rd), .first_opcode_field(u_pipe.o1), .minor_coproc_reg_field(u_pipe.mi),
      .first_xfer_reg_field(u_pipe.r1), .second_xfer_reg_field(u_pipe.r2),
      .base_reg_field(u_pipe.bs), .byte_immediate_field(u_pipe.im), .literal_form(u_pipe.lt),
      .pre_index(u_pipe.pi), .writeback(u_pipe.wb), .add_offset(u_pipe.ad),
      .trace_target(u_pipe.tt), .trace_undef(u_pipe.tu)
   );
   ////////////////////////////////////////////////////////////
   function automatic logic [4:0] spec(input logic [3:0] s);
      return (s != 4'hF) ? {1'b0, s} : (!u_pipe.un || ctl_m[2]) ? 5'h1F : 5'h0F;
   endfunction : spec
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wbx(input logic we, input logic [3:0] a, input logic [3:0] s,
      input logic [31:0] d);
      @(posedge clk_sys);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, a, s, d};
      // Ends on the ack; only the bench ceiling ends a wait for an ack that never comes
      do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask : wbx
   task automatic results(input logic hung);
      n_errors += hung;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results
   ////////////////////////////////////////////////////////////
   // Ceiling well above the roughly 840 cycles that the tests need
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 8000)
         results(1'b1);
   end
   // Reference model; undefined takes blind the class and syndrome until the next report
   always @(posedge clk_sys)
   begin
      {ev, eu, vf, cd} = {3'h1, 4'hE};
      if (!u_pipe.ws && u_pipe.mw)
         {vf, cd} = ctl_m[0] ? {1'b1, u_pipe.cn ? u_pipe.cc : 4'hE} : 5'h00;
      else if (!u_pipe.ws && u_pipe.cn)
         cd = (u_pipe.kp && ctl_m[1]) ? 4'hE : u_pipe.cc;
      if (rst)
         {xc, es, r2_m, rl_m, lc_m, ts_m, us_m} = '0;
      else if (u_pipe.v && u_pipe.k)
      begin
         {ev, xc} = {1'b1, 6'h06};
         es = {vf, cd, u_pipe.im, 2'h0, u_pipe.lt ? 5'h00 : spec(u_pipe.bs), u_pipe.ad,
            u_pipe.lt, u_pipe.pi, u_pipe.wb, u_pipe.rd};
         rl_m = es;
         {ts_m, lc_m} = {1'b1, xc};
      end
      else if (u_pipe.v && u_pipe.tt && u_pipe.tu)
         {eu, us_m} = 2'h3;
      else if (u_pipe.v && u_pipe.sp[3:1] == 3'h7)
      begin
         {ev, xc} = {1'b1, u_pipe.sp[0] ? 6'h04 : 6'h0C};
         es = {vf, cd, u_pipe.o1, 1'b0, spec(u_pipe.r2), spec(u_pipe.r1),
            u_pipe.mi, u_pipe.rd};
         r2_m = es;
         {ts_m, lc_m} = {1'b1, xc};
      end
      blind = !rst && (eu || hide || (blind && !ev));
   end
   always @(negedge clk_sys)
   begin
      if (!rst)
         chk({30'h0, exc_valid, undef_take}, {30'h0, ev, eu});
      if (!rst && !blind)
         chk({1'b0, exception_class_code, syndrome_detail}, {1'b0, xc, es});
   end
   ////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(32'h1AA7));
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      wbx(1'b0, 4'hC, 4'hF, 32'h0);
      chk(q, 32'h0);
      wbx(1'b0, 4'h2, 4'hF, 32'h0);
      chk(q, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         // Lane 0 unselected, so this write must leave control alone
         wbx(1'b1, 4'hC, 4'hE, 32'h7);
         wbx(1'b1, 4'hC, 4'h1, {29'h0, ph[i]});
         ctl_m = ph[i];
         wbx(1'b0, 4'hC, 4'hF, 32'h0);
         chk(q, {29'h0, ctl_m});
         repeat (250) u_pipe.issue();
         @(posedge clk_sys);
         u_pipe.fill(1'b0);
         wbx(1'b0, 4'h0, 4'hF, 32'h0);
         chk(q, {7'h0, r2_m});
         wbx(1'b0, 4'h4, 4'hF, 32'h0);
         chk(q, {7'h0, rl_m});
         $display("Trap phase %0d done, control %h", i, ctl_m);
      end
      hide = 1'b1;
      wbx(1'b1, 4'h4, 4'hF, 32'hFFFFFFFF);
      wbx(1'b0, 4'h4, 4'hF, 32'h0);
      chk(q, 32'h01FFF3FF);
      wbx(1'b1, 4'h0, 4'h3, 32'h0155AAAA);
      wbx(1'b0, 4'h0, 4'hF, 32'h0);
      chk(q, {7'h0, r2_m[24:16], 16'hAAAA});
      wbx(1'b0, 4'h8, 4'hF, 32'h0);
      chk(q, {22'h0, ts_m, us_m, 2'h0, lc_m});
      wbx(1'b1, 4'h8, 4'h2, 32'h300);
      {ts_m, us_m} = 2'h0;
      wbx(1'b0, 4'h8, 4'hF, 32'h0);
      chk(q, {22'h0, ts_m, us_m, 2'h0, lc_m});
      $display("Register phase done");
      results(1'b0);
   end
endmodule : test_coproc_trap_syndrome_encoder
`default_nettype wire
